// file: pwpt_channel.v
`timescale 1ns/1ps
`include "pwpt_regs.vh"
module pwpt_channel (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire tick,
  input wire enable,
  input wire polarity,
  input wire centre,
  input wire period_disable,
  input wire cnt_wr,
  input wire cnt_reset_disable,
  input wire [7:0] duty_wr_data,
  input wire duty_wr,
  input wire [7:0] period_wr_data,
  input wire period_wr,
  output reg [7:0] duty_q,
  output reg [7:0] period_q,
  output reg [7:0] count_q,
  output reg wave_q
);
  reg [7:0] duty_buf_q;
  reg [7:0] period_buf_q;
  reg down_q;
  reg [7:0] count_d;
  reg down_d;
  reg wave_d;
  wire left_match;
  wire load;
  assign left_match = (count_q == period_q);
  assign load = cnt_wr || !enable || (!centre && left_match && !period_disable) || (centre && count_q == 8'h00);

  // ----------------------------------------
  // Counter stepping
  // ----------------------------------------
  always @* begin
    count_d = count_q;
    down_d = down_q;
    if (cnt_wr) begin
      // [R3] Write resets counter
      // [R14] Unless disabled in test
      if (!cnt_reset_disable) begin
        count_d = `PWPT_RST_COUNT;
        down_d = 1'b0;
      end
    end else if (enable && tick) begin
      if (!centre) begin
        // [R4] Period match may wrap
        if (left_match && !period_disable) count_d = 8'h00;
        else count_d = count_q + 8'h01;
      end else begin
        // [R17] Up/down in centre mode
        if (!down_q && count_q + 8'h01 >= period_q) begin
          down_d = 1'b1;
          count_d = period_q;
        end else if (down_q && count_q <= 8'h01) begin
          down_d = 1'b0;
          count_d = 8'h00;
        end else if (down_q) count_d = count_q - 8'h01;
        else count_d = count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Output level with boundary cases
  // ----------------------------------------
  always @* begin
    // [R12] Left boundary levels
    // [R13] Centre boundary levels
    if (!centre && duty_q == 8'hFF && period_q != 8'h00) wave_d = !polarity;
    else if (centre && duty_q == 8'h00 && period_q != 8'h00) wave_d = !polarity;
    else if (duty_q >= period_q || period_q == 8'h00) wave_d = polarity;
    else if (!centre) wave_d = (count_q <= duty_q) ? polarity : !polarity;
    else wave_d = (count_q < duty_q) ? polarity : !polarity;
  end

  // Buffered duty and period, taken at rollover so periods stay whole
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_buf_q <= `PWPT_RST_DUTY;
      period_buf_q <= `PWPT_RST_PERIOD;
      duty_q <= `PWPT_RST_DUTY;
      period_q <= `PWPT_RST_PERIOD;
      count_q <= `PWPT_RST_COUNT;
      down_q <= 1'b0;
      wave_q <= 1'b0;
    end else if (ce) begin
      if (duty_wr) duty_buf_q <= duty_wr_data;
      if (period_wr) period_buf_q <= period_wr_data;
      if (load && (tick || cnt_wr || !enable)) begin
        duty_q <= duty_wr ? duty_wr_data : duty_buf_q;
        period_q <= period_wr ? period_wr_data : period_buf_q;
      end
      count_q <= count_d;
      down_q <= down_d;
      wave_q <= enable ? wave_d : polarity;
    end
  end
endmodule

// file: pwpt_chk.sv
`timescale 1ns/1ps
`include "pwpt_regs.vh"
// ----------------------------------------
// Port-level checks
// ----------------------------------------
module pwpt_chk (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PWPT_ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire normal_mode_select_n,
  input wire background_mode,
  input wire [7:0] port_pin_in,
  input wire [7:0] port_pin_out,
  input wire [7:0] port_pin_oe,
  input wire port_pullup_enable,
  input wire port_reduced_drive
);
  // Accesses that clk_en lets through; frozen cycles change nothing
  wire acc = psel && penable && clk_en;
  wire wr_dir = acc && pwrite && paddr == {`PWPT_IDX_PORT_DIR, 2'b00};
  wire wr_dat = acc && pwrite && paddr == {`PWPT_IDX_PORT_DATA, 2'b00};
  wire wr_ctl = acc && pwrite && paddr == {`PWPT_IDX_CTRL, 2'b00};
  wire rd_tst = acc && !pwrite && paddr == {`PWPT_IDX_TEST, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("misaligned access without pslverr");
  property p_rst; $rose(presetn) |-> port_pin_oe == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  property p_tlow; rd_tst |-> prdata[4:0] == 5'h00 && prdata[31:8] == 24'h000000; endproperty
  a_tlow: assert property (p_tlow) else $error("test register low bits set");
  property p_tnorm;
    rd_tst && $past(normal_mode_select_n, 3) && $past(normal_mode_select_n, 4) && $past(normal_mode_select_n, 5)
      |-> prdata[7:5] == 3'h0;
  endproperty
  a_tnorm: assert property (p_tnorm) else $error("test bits set in normal mode");
  property p_dir; wr_dir ##1 clk_en |=> port_pin_oe[7:4] == $past(pwdata[7:4], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction not on pin enables");
  property p_out;
    wr_dat ##1 clk_en |=> ((port_pin_out ^ $past(pwdata[7:0], 2)) & port_pin_oe & 8'hF0) == 8'h00;
  endproperty
  a_out: assert property (p_out) else $error("output pin not driven with data");
  property p_pu; wr_ctl |=> port_pullup_enable == $past(pwdata[9]) && port_reduced_drive == $past(pwdata[10]); endproperty
  a_pu: assert property (p_pu) else $error("pull-up or drive level wrong");
  property p_en; wr_ctl ##1 clk_en |=> (port_pin_oe[3:0] & $past(pwdata[3:0], 2)) == $past(pwdata[3:0], 2); endproperty
  a_en: assert property (p_en) else $error("enabled channel pin not driven");
  c_ctl: cover property (wr_ctl && pwdata[0]);
  c_err: cover property (acc && pslverr);
  c_spec: cover property (rd_tst && !normal_mode_select_n);
endmodule
bind pwpt_top pwpt_chk i_pwpt_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .normal_mode_select_n(normal_mode_select_n), .background_mode(background_mode), .port_pin_in(port_pin_in),
  .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .port_pullup_enable(port_pullup_enable),
  .port_reduced_drive(port_reduced_drive));

// file: pwpt_load.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board loads on the shared port
// ----------------------------------------
module pwpt_load (
  input wire pclk,
  input wire [7:0] port_pin_out,
  input wire [7:0] port_pin_oe,
  input wire port_pullup_enable,
  input wire [7:0] ext_val,
  input wire [7:0] ext_drive,
  output wire [7:0] pin_level
);
  reg [7:0] wander = 8'hA5;
  // Floating pins toggle so a stale level never passes
  always @(posedge pclk) wander <= ~wander;
  assign pin_level = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext_drive & ext_val)
    | (~port_pin_oe & ~ext_drive & (port_pullup_enable ? 8'hFF : wander));
endmodule

// file: pwpt_regs.vh
`ifndef PWPT_REGS_VH
`define PWPT_REGS_VH
// ----------------------------------------
// Register word indices (byte address is index times four)
// ----------------------------------------
`define PWPT_IDX_PORT_DATA 8'h56
`define PWPT_IDX_PORT_DIR 8'h57
`define PWPT_IDX_TEST 8'h58
`define PWPT_IDX_CTRL 8'h59
`define PWPT_IDX_STATUS 8'h5A
`define PWPT_IDX_DUTY0 8'h50
`define PWPT_IDX_PERIOD0 8'h4C
`define PWPT_IDX_COUNT0 8'h48
`define PWPT_IDX_SCALE0 8'h5C
`define PWPT_IDX_SCALE1 8'h5D
`define PWPT_ADDR_WIDTH 10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWPT_TEST_CR_BIT 7
`define PWPT_TEST_CP_BIT 6
`define PWPT_TEST_CAL_BIT 5
`define PWPT_CTRL_EN_LSB 0
`define PWPT_CTRL_POL_LSB 4
`define PWPT_CTRL_CENTRE_BIT 8
`define PWPT_CTRL_PULLUP_BIT 9
`define PWPT_CTRL_REDUCED_BIT 10
`define PWPT_CTRL_BGSTOP_BIT 11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWPT_RST_TEST 8'h00
`define PWPT_RST_DIR 8'h00
`define PWPT_RST_DATA 8'h00
`define PWPT_RST_DUTY 8'hFF
`define PWPT_RST_PERIOD 8'hFF
`define PWPT_RST_COUNT 8'h00
`define PWPT_RST_SCALE 8'h00
`define PWPT_RST_CTRL 12'h000
`endif

// file: pwpt_top.v
`timescale 1ns/1ps
`include "pwpt_regs.vh"
// Summary of operation
// [R1] Background stop gates PWM clock
// [R2] Test register writable only special mode
// [R3] Counter-reset-disable blocks counter write reset
// [R4] Period-compare-disable blocks left-aligned wrap
// [R5] Scaler-load-disable blocks scaler load on a scale write
// [R6] Enabled channel owns port pins 3-0
// [R7] Port read: pin if input, latch if output
// [R8] Port write drives only free outputs
// [R9] Reset leaves all pins as inputs
// [R10] Direction bit: 0 input, 1 output
// [R11] Port-wide pull-up and reduced-drive bits
// [R12] Left-aligned boundary output levels
// [R13] Centre-aligned boundary output levels
// [R14] Counter write clears to zero normally
// [R15] Scale write loads its down-counter
// [R16] Enable forces output, keeps direction bit
// [R17] Alignment bit selects left or centre
// [R18] Test low five bits read zero
module pwpt_top (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PWPT_ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire normal_mode_select_n,
  input wire background_mode,
  input wire [7:0] port_pin_in,
  output reg [7:0] port_pin_out,
  output reg [7:0] port_pin_oe,
  output wire port_pullup_enable,
  output wire port_reduced_drive
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [7:0] pin_meta_q;
  reg [7:0] pin_sync_q;
  reg [7:0] shared_port_data_q;
  reg [7:0] shared_port_direction_q;
  reg [7:0] special_test_register_q;
  reg [11:0] ctrl_q;
  reg [7:0] scale_q [0:1];
  reg [7:0] scale_cnt_q [0:1];
  reg [1:0] scale_tick_q;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;
  reg [7:0] port_out_d;
  reg [7:0] port_oe_d;
  reg mode_meta_q;
  reg mode_sync_q;
  reg bg_meta_q;
  reg bg_sync_q;
  wire wr_en;
  wire rd_en;
  wire [7:0] word_idx;
  wire addr_ok;
  wire run_en;
  wire [3:0] channel_enable;
  wire [3:0] channel_polarity;
  wire centre_align_select;
  wire background_clock_stop;
  wire counter_reset_disable;
  wire period_compare_disable;
  wire scaler_load_disable;
  wire [3:0] wave;
  wire [31:0] chan_cnt_rd;
  wire [31:0] chan_duty_rd;
  wire [31:0] chan_per_rd;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Zero-wait slave; word index is the printed offset, byte address four times it
  assign word_idx = paddr[`PWPT_ADDR_WIDTH-1:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && ((word_idx >= `PWPT_IDX_COUNT0 && word_idx <= `PWPT_IDX_STATUS)
                   || word_idx == `PWPT_IDX_SCALE0 || word_idx == `PWPT_IDX_SCALE1);
  assign wr_en = psel && penable && pwrite && addr_ok && clk_en;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;

  // Field aliases from the control and test registers
  assign channel_enable = ctrl_q[`PWPT_CTRL_EN_LSB+3:`PWPT_CTRL_EN_LSB];
  assign channel_polarity = ctrl_q[`PWPT_CTRL_POL_LSB+3:`PWPT_CTRL_POL_LSB];
  // [R17] One alignment bit
  assign centre_align_select = ctrl_q[`PWPT_CTRL_CENTRE_BIT];
  // [R11] Port-wide pad controls
  assign port_pullup_enable = ctrl_q[`PWPT_CTRL_PULLUP_BIT];
  assign port_reduced_drive = ctrl_q[`PWPT_CTRL_REDUCED_BIT];
  assign background_clock_stop = ctrl_q[`PWPT_CTRL_BGSTOP_BIT];
  assign counter_reset_disable = special_test_register_q[`PWPT_TEST_CR_BIT];
  assign period_compare_disable = special_test_register_q[`PWPT_TEST_CP_BIT];
  assign scaler_load_disable = special_test_register_q[`PWPT_TEST_CAL_BIT];

  // [R1] Stop PWM clock in background
  assign run_en = clk_en && !(background_clock_stop && bg_sync_q);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
      mode_meta_q <= 1'b1;
      mode_sync_q <= 1'b1;
      bg_meta_q <= 1'b0;
      bg_sync_q <= 1'b0;
    end else if (clk_en) begin
      pin_meta_q <= port_pin_in;
      pin_sync_q <= pin_meta_q;
      mode_meta_q <= normal_mode_select_n;
      mode_sync_q <= mode_meta_q;
      bg_meta_q <= background_mode;
      bg_sync_q <= bg_meta_q;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_port_data_q <= `PWPT_RST_DATA;
      // [R9] All pins inputs at reset
      shared_port_direction_q <= `PWPT_RST_DIR;
      special_test_register_q <= `PWPT_RST_TEST;
      ctrl_q <= `PWPT_RST_CTRL;
    end else if (clk_en) begin
      if (wr_en && word_idx == `PWPT_IDX_PORT_DATA)
        shared_port_data_q <= pwdata[7:0];
      if (wr_en && word_idx == `PWPT_IDX_PORT_DIR)
        shared_port_direction_q <= pwdata[7:0];
      if (wr_en && word_idx == `PWPT_IDX_CTRL)
        ctrl_q <= pwdata[11:0];
      // [R2] Held at reset in normal mode
      if (mode_sync_q)
        special_test_register_q <= `PWPT_RST_TEST;
      else if (wr_en && word_idx == `PWPT_IDX_TEST)
        // [R18] Low five bits stay zero
        special_test_register_q <= {pwdata[7:5], 5'b00000};
    end
  end

  // ----------------------------------------
  // Scalers
  // ----------------------------------------
  // Each down-counter reloads at zero and emits a tick to channel pairs
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_scale
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          scale_q[s] <= `PWPT_RST_SCALE;
          scale_cnt_q[s] <= `PWPT_RST_SCALE;
          scale_tick_q[s] <= 1'b0;
        end else if (run_en) begin
          scale_tick_q[s] <= 1'b0;
          if (wr_en && word_idx == `PWPT_IDX_SCALE0 + s) begin
            scale_q[s] <= pwdata[7:0];
            // [R5] Load may be suppressed
            // [R15] Write loads down-counter
            if (!scaler_load_disable)
              scale_cnt_q[s] <= pwdata[7:0];
          end else if (scale_cnt_q[s] == 8'h00) begin
            scale_cnt_q[s] <= scale_q[s];
            scale_tick_q[s] <= 1'b1;
          end else begin
            scale_cnt_q[s] <= scale_cnt_q[s] - 8'h01;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_chan
      pwpt_channel u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .ce(run_en),
        .tick(scale_tick_q[c/2]),
        .enable(channel_enable[c]),
        .polarity(channel_polarity[c]),
        .centre(centre_align_select),
        .period_disable(period_compare_disable),
        .cnt_wr(wr_en && word_idx == `PWPT_IDX_COUNT0 + c),
        .cnt_reset_disable(counter_reset_disable),
        .duty_wr_data(pwdata[7:0]),
        .duty_wr(wr_en && word_idx == `PWPT_IDX_DUTY0 + c),
        .period_wr_data(pwdata[7:0]),
        .period_wr(wr_en && word_idx == `PWPT_IDX_PERIOD0 + c),
        .duty_q(chan_duty_rd[8*c+7:8*c]),
        .period_q(chan_per_rd[8*c+7:8*c]),
        .count_q(chan_cnt_rd[8*c+7:8*c]),
        .wave_q(wave[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always @* begin
    // [R10] Direction bit sets enable
    // [R8] Latch drives free outputs only
    port_oe_d = shared_port_direction_q;
    port_out_d = shared_port_data_q;
    // [R6] Channel owns its pin
    // [R16] Enable forces output drive
    port_oe_d[3:0] = shared_port_direction_q[3:0] | channel_enable;
    port_out_d[3:0] = (shared_port_data_q[3:0] & ~channel_enable) | (wave & channel_enable);
  end

  // Registered pad drive keeps glitches off the board
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_out <= 8'h00;
      port_pin_oe <= 8'h00;
    end else if (clk_en) begin
      port_pin_out <= port_out_d;
      port_pin_oe <= port_oe_d;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    prdata_d = 32'h00000000;
    case (word_idx)
      // [R7] Pin for inputs, latch for outputs
      `PWPT_IDX_PORT_DATA: prdata_d[7:0] = (shared_port_data_q & shared_port_direction_q)
                                          | (pin_sync_q & ~shared_port_direction_q);
      `PWPT_IDX_PORT_DIR: prdata_d[7:0] = shared_port_direction_q;
      `PWPT_IDX_TEST: prdata_d[7:0] = special_test_register_q;
      `PWPT_IDX_CTRL: prdata_d[11:0] = ctrl_q;
      `PWPT_IDX_STATUS: prdata_d[5:0] = {bg_sync_q, !mode_sync_q, wave};
      `PWPT_IDX_SCALE0: prdata_d[7:0] = scale_q[0];
      `PWPT_IDX_SCALE1: prdata_d[7:0] = scale_q[1];
      default: begin
        if (word_idx >= `PWPT_IDX_COUNT0 && word_idx < `PWPT_IDX_PERIOD0)
          prdata_d[7:0] = chan_cnt_rd[8*(word_idx-`PWPT_IDX_COUNT0) +: 8];
        else if (word_idx >= `PWPT_IDX_PERIOD0 && word_idx < `PWPT_IDX_DUTY0)
          prdata_d[7:0] = chan_per_rd[8*(word_idx-`PWPT_IDX_PERIOD0) +: 8];
        else if (word_idx >= `PWPT_IDX_DUTY0 && word_idx < `PWPT_IDX_DUTY0 + 8'h04)
          prdata_d[7:0] = chan_duty_rd[8*(word_idx-`PWPT_IDX_DUTY0) +: 8];
      end
    endcase
  end

  // Read data captured in setup so it is stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (clk_en && rd_en) begin
      prdata_q <= prdata_d;
    end
  end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`include "pwpt_regs.vh"
module tb_top;
  // ----------------------------------------
  // Bench for the PWM port block
  // ----------------------------------------
  localparam [9:0] A_DAT = {`PWPT_IDX_PORT_DATA, 2'b00};
  localparam [9:0] A_DIR = {`PWPT_IDX_PORT_DIR, 2'b00};
  localparam [9:0] A_TST = {`PWPT_IDX_TEST, 2'b00};
  localparam [9:0] A_CTL = {`PWPT_IDX_CTRL, 2'b00};
  localparam [9:0] A_CNT = {`PWPT_IDX_COUNT0, 2'b00};
  localparam [9:0] A_PER = {`PWPT_IDX_PERIOD0, 2'b00};
  localparam [9:0] A_DTY = {`PWPT_IDX_DUTY0, 2'b00};
  localparam [9:0] A_SC0 = {`PWPT_IDX_SCALE0, 2'b00};
  reg pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg nm_n = 1'b1, bg = 1'b0, err, ctr, pol, e;
  reg [9:0] paddr = 10'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [7:0] ext_val = 8'h00, ext_drv = 8'h00, seed = 8'h5C, d, w, dt, pr, c;
  wire [31:0] prdata;
  wire pready, pslverr, pu, rdd;
  wire [7:0] pin_in, pin_out, pin_oe;
  integer mismatches = 0, check_count = 0, i;
  pwpt_top i_pwpt_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .normal_mode_select_n(nm_n), .background_mode(bg), .port_pin_in(pin_in), .port_pin_out(pin_out),
    .port_pin_oe(pin_oe), .port_pullup_enable(pu), .port_reduced_drive(rdd));
  pwpt_load i_pwpt_load (.pclk(pclk), .port_pin_out(pin_out), .port_pin_oe(pin_oe), .port_pullup_enable(pu),
    .ext_val(ext_val), .ext_drive(ext_drv), .pin_level(pin_in));
  // Clock, 20 ns period
  initial forever #10 pclk = ~pclk;
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Fixed level for boundary duty and period values
  function bnd(input ct, input [7:0] du, input [7:0] pe, input po);
    bnd = (pe != 8'h00 && (ct ? du == 8'h00 : du == 8'hFF)) ? ~po : po;
  endfunction
  task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task apb(input wr, input [9:0] a, input [31:0] wd);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 50) mismatches = mismatches + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Run channel 0 for a while, stop it, read its counter into c
  task run0(input integer n);
    begin
      apb(1'b1, A_CTL, 32'h1);
      repeat (n) @(posedge pclk);
      apb(1'b1, A_CTL, 32'h0);
      apb(1'b0, A_CNT, 32'h0);
      c = rd[7:0];
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches = mismatches + 1;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_DIR, 32'h0);
    chk("dir", rd, 32'h0);
    chk("oe", {24'h0, pin_oe}, 32'h0);
    apb(1'b1, A_TST, 32'hE0);
    apb(1'b0, A_TST, 32'h0);
    chk("tstnorm", rd, 32'h0);
    apb(1'b0, 10'h3FC, 32'h0);
    chk("err", {31'h0, err}, 32'h1);
    clk_en <= 1'b0;
    apb(1'b1, A_DIR, 32'hFF);
    clk_en <= 1'b1;
    apb(1'b0, A_DIR, 32'h0);
    chk("frozen", rd, 32'h0);
    // Random direction and data, all-in and all-out corners first
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed;
      seed = lfsr(seed);
      w = seed;
      seed = lfsr(seed);
      ext_val <= seed;
      ext_drv <= 8'hFF;
      apb(1'b1, A_DIR, {24'h0, d});
      apb(1'b1, A_DAT, {24'h0, w});
      repeat (4) @(posedge pclk);
      apb(1'b0, A_DAT, 32'h0);
      chk("port", rd, {24'h0, (w & d) | (ext_val & ~d)});
      chk("oe", {24'h0, pin_oe}, {24'h0, d});
      chk("out", {24'h0, pin_out & d}, {24'h0, w & d});
    end
    ext_drv <= 8'h00;
    apb(1'b1, A_DIR, 32'h0);
    apb(1'b1, A_CTL, 32'h600);
    repeat (4) @(posedge pclk);
    apb(1'b0, A_DAT, 32'h0);
    chk("pull", {22'h0, rdd, pu, rd[7:0]}, 32'h3FF);
    // Boundary table: alignment, polarity and three boundary kinds
    for (i = 0; i < 12; i = i + 1) begin
      seed = lfsr(seed);
      pol = i[0];
      ctr = i[1];
      dt = (i < 4) ? (ctr ? 8'h00 : 8'hFF) : (i < 8) ? 8'h30 : seed;
      pr = (i < 4) ? 8'h10 : (i < 8) ? 8'h30 : 8'h00;
      e = bnd(ctr, dt, pr, pol);
      apb(1'b1, A_CTL, {23'h0, ctr, 3'h0, pol, 4'h0});
      apb(1'b1, A_DTY, {24'h0, dt});
      apb(1'b1, A_PER, {24'h0, pr});
      apb(1'b1, A_CNT, 32'h0);
      apb(1'b1, A_CTL, {23'h0, ctr, 3'h0, pol, 4'h1});
      apb(1'b1, A_DAT, {31'h0, ~e});
      repeat (8) @(posedge pclk);
      chk("wave", {31'h0, pin_out[0]}, {31'h0, e});
      chk("oe0", {31'h0, pin_oe[0]}, 32'h1);
      apb(1'b0, A_DIR, 32'h0);
      chk("dirkept", rd, 32'h0);
    end
    // Special mode: test controls on the counter
    nm_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, A_TST, 32'hFF);
    apb(1'b0, A_TST, 32'h0);
    chk("tstspec", rd, 32'hE0);
    apb(1'b1, A_TST, 32'h0);
    apb(1'b1, A_PER, 32'hFF);
    apb(1'b1, A_CNT, 32'h0);
    run0(30);
    apb(1'b1, A_CNT, 32'h55);
    apb(1'b0, A_CNT, 32'h0);
    chk("cntclr", rd, 32'h0);
    run0(30);
    apb(1'b1, A_TST, 32'h80);
    apb(1'b1, A_CNT, 32'h55);
    apb(1'b0, A_CNT, 32'h0);
    chk("cntkeep", rd, {24'h0, c});
    apb(1'b1, A_PER, 32'h4);
    apb(1'b1, A_TST, 32'h0);
    apb(1'b1, A_CNT, 32'h0);
    run0(60);
    chk("perwrap", {31'h0, c <= 8'h04}, 32'h1);
    apb(1'b1, A_TST, 32'h40);
    apb(1'b1, A_CNT, 32'h0);
    run0(60);
    chk("pernowrap", {31'h0, c > 8'h04}, 32'h1);
    // Scaler load disable: a long count left running starves the channel
    apb(1'b1, A_PER, 32'hFF);
    apb(1'b1, A_TST, 32'h0);
    apb(1'b1, A_SC0, 32'hFF);
    apb(1'b1, A_TST, 32'h20);
    apb(1'b1, A_SC0, 32'h0);
    apb(1'b1, A_CNT, 32'h0);
    run0(30);
    chk("sclhold", {24'h0, c}, 32'h0);
    apb(1'b1, A_TST, 32'h0);
    apb(1'b1, A_SC0, 32'h0);
    apb(1'b1, A_CNT, 32'h0);
    run0(30);
    chk("sclload", {31'h0, c != 8'h00}, 32'h1);
    // Background stop freezes the running counter
    apb(1'b1, A_PER, 32'hFF);
    apb(1'b1, A_CTL, 32'h801);
    bg <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    c = rd[7:0];
    repeat (20) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    chk("bgstop", rd, {24'h0, c});
    final_report;
  end
endmodule
